/* hdl/tccc_pkg.sv */
/*
 * Package for the two-channel capture/compare configuration block:
 * register offsets, field positions, reset values, filter and mode codes.
 * Assumes a 10 MHz kernel clock and a 32-bit Avalon-MM register port.
 */
package tccc_pkg;

    // Byte addresses of the registers
    localparam logic [7:0]  MODE_CTRL_OFS  = 8'h18;
    localparam logic [7:0]  ENA_POL_OFS    = 8'h20;
    localparam logic [7:0]  PROTECT_OFS    = 8'h44;
    localparam logic [7:0]  STATUS_OFS     = 8'h48;

    // Reset values
    localparam logic [15:0] MODE_CTRL_RST  = 16'h0000;
    localparam logic [15:0] ENA_POL_RST    = 16'h0000;
    localparam logic [1:0]  PROTECT_RST    = 2'h0;

    // Mode control fields, channel 0 base; channel 1 sits CH_STRIDE higher
    localparam int MC_DIR_LSB   = 0;
    localparam int MC_DIV_LSB   = 2;
    localparam int MC_FAST_BIT  = 2;
    localparam int MC_FLT_LSB   = 4;
    localparam int MC_CMP_LSB   = 4;
    localparam int CH_STRIDE    = 8;

    // Enable/polarity fields, channel 0 base; channel 1 sits EP_STRIDE higher
    localparam int EP_EN_BIT    = 0;
    localparam int EP_POL_BIT   = 1;
    localparam int EP_NPOL_BIT  = 3;
    localparam int EP_STRIDE    = 4;
    localparam logic [15:0] ENA_POL_MASK = 16'h00BB;

    // Compare output modes that enable the fast path
    localparam logic [2:0]  PWM_FIRST_MODE  = 3'h6;
    localparam logic [2:0]  PWM_SECOND_MODE = 3'h7;

    // Direction / source selection codes
    localparam logic [1:0]  DIR_OUTPUT   = 2'h0;
    localparam logic [1:0]  DIR_OWN_IN   = 2'h1;
    localparam logic [1:0]  DIR_OTHER_IN = 2'h2;
    localparam logic [1:0]  DIR_TRIG_IN  = 2'h3;

    // Protection levels that lock the complementary polarity bit
    localparam logic [1:0]  PROTECTION_LEVEL_LOCK_A  = 2'h2;
    localparam logic [1:0]  PROTECTION_LEVEL_LOCK_B  = 2'h3;

    // Sampling clock choices of the input filter
    typedef enum logic [2:0] {
        TCCC_SMP_KERNEL,
        TCCC_SMP_DTS2,
        TCCC_SMP_DTS4,
        TCCC_SMP_DTS8,
        TCCC_SMP_DTS16,
        TCCC_SMP_DTS32
    } tccc_smp_t;

    // Per-channel configuration passed to the filter
    typedef struct packed {
        logic      bypass;
        tccc_smp_t rate;
        logic [3:0] count;
    } tccc_flt_cfg_t;

    // Per-channel status seen by software
    typedef struct packed {
        logic       capture;
        logic       output_lvl;
        logic       edge_in;
    } tccc_ch_stat_t;

endpackage

/* hdl/tccc_filter.sv */
/*
 * Digital input filter of one channel: samples a synchronised input at the
 * chosen rate and passes a level only after a run of equal samples, or at once in bypass.
 * Assumes the input is already in the kernel clock domain.
 */
module tccc_filter
    import tccc_pkg::*;
(
    input  wire logic          i_sys_clk,   // Kernel clock
    input  wire logic          i_resetn,    // Async reset, active low
    input  wire logic          i_ce,        // Clock enable
    input  wire logic          i_smp_tick,  // Sampling strobe at chosen rate
    input  wire tccc_flt_cfg_t i_cfg,       // Filter configuration
    input  wire logic          i_in,        // Synchronised raw input
    output logic               o_filt       // Filtered level
);
    logic       last_r, last_nxt;
    logic       filt_r, filt_nxt;
    logic [3:0] run_r, run_nxt;

    always_comb begin
        last_nxt = last_r;
        filt_nxt = filt_r;
        run_nxt  = run_r;
        if (i_cfg.bypass) begin
            filt_nxt = i_in;
            last_nxt = i_in;
            run_nxt  = 4'h0;
        end else if (i_smp_tick) begin
            last_nxt = i_in;
            // R20 - restart on change
            if (i_in != last_r) begin
                run_nxt = 4'h1;
            // R5 - count equal samples
            end else if (run_r < i_cfg.count) begin
                run_nxt = run_r + 4'h1;
            end
            if (i_in == last_r && run_r + 4'h1 >= i_cfg.count) begin
                filt_nxt = i_in;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            last_r <= 1'b0;
            filt_r <= 1'b0;
            run_r  <= 4'h0;
        end else if (i_ce) begin
            last_r <= last_nxt;
            filt_r <= filt_nxt;
            run_r  <= run_nxt;
        end
    end

    assign o_filt = filt_r;
endmodule

/* hdl/tccc_top.sv */
/*
 * Two-channel capture/compare configuration of a 16-bit timer: mode control
 * and enable/polarity registers, input filters, source selection, polarity,
 * capture edge divider and the fast compare path.
 * Assumes one 10 MHz kernel clock, a dead-time sample strobe from the timer,
 * and compare levels from neighbouring blocks; the protection level is a bus register.
 */
// Behaviour
// R1 - Fast compare: trigger edge forces PWM level
// R2 - Direction field writable only while disabled
// R3 - Direction codes: output, own, other, trigger
// R4 - Software picks internal trigger elsewhere
// R5 - Filter passes level after equal-sample run
// R6 - Codes 0..3: bypass, kernel rate 2/4/8
// R7 - Codes 4..9: dead-time /2 /4 /8, 6/8
// R8 - Codes 10..15: /16, /32 with 5/6/8
// R9 - Capture divider: every 1/2/4/8 edges
// R10 - Divider counter cleared while channel disabled
// R11 - Complementary polarity joins polarity on input
// R12 - Complementary polarity locked at protection 2/3
// R13 - Output polarity 1 means active low
// R14 - Channel 0 input fields in low byte
// R15 - Channel 1 input fields in high byte
// R16 - Enable/polarity bit positions per channel
// R17 - Software keeps reserved bits at reset
// R18 - Enable gates output and capture events
// R19 - Input polarity: rising or falling, inverted
// R20 - Filter run restarts on any change
module tccc_top
    import tccc_pkg::*;
(
    input  wire logic        i_sys_clk,            // Kernel clock, 10 MHz
    input  wire logic        i_resetn,             // Async reset, active low
    input  wire logic        i_ce,                 // Clock enable, freezes all
    input  wire logic [7:0]  i_avs_address,        // Byte address
    input  wire logic        i_avs_read,           // Read request
    input  wire logic        i_avs_write,          // Write request
    input  wire logic [31:0] i_avs_writedata,      // Write data
    input  wire logic [3:0]  i_avs_byteenable,     // Byte lanes
    output logic [31:0]      o_avs_readdata,       // Read data
    output logic             o_avs_waitrequest,    // Wait request
    input  wire logic        i_dts_tick,           // Dead-time sample strobe
    input  wire logic [1:0]  i_ch_raw_input,       // Raw channel pins
    input  wire logic        i_internal_trigger,   // Internal trigger source
    input  wire logic        i_trig_edge,          // Active trigger-input edge
    input  wire logic [1:0]  i_cmp_level,          // Compare reference level
    output logic [1:0]       o_ch_output,          // Channel output pins
    output logic [1:0]       o_ch_output_en,       // Output drive enable
    output logic [1:0]       o_capture,            // Capture event pulse
    output logic [1:0]       o_selected_edge       // Selected edge pulse
);
    logic [15:0] mode_r, mode_nxt;
    logic [15:0] ep_r, ep_nxt;
    logic [1:0]  protection_level_r, protection_level_nxt;
    logic        ack_r, ack_nxt;
    logic        wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  sync1_r, sync2_r;
    logic        trig_s1_r, trig_s2_r;
    logic [4:0]  dts_div_r, dts_div_nxt;
    logic [4:0]  dts_prev_r;
    logic [1:0]  filt;
    logic [1:0]  pol_in;
    logic [1:0]  sel_r, sel_nxt;
    logic [1:0]  edge_now;
    logic [2:0]  edge_cnt_r [2];
    logic [2:0]  edge_cnt_nxt [2];
    logic [1:0]  cap_r, cap_nxt;
    logic [1:0]  sel_edge_r, sel_edge_nxt;
    logic [1:0]  out_r, out_nxt;
    logic [1:0]  oen_r, oen_nxt;
    logic [1:0]  fast_hold_nxt;
    logic        wr_hit, rd_hit;

    // Filter code decode, shared by both channels
    function automatic tccc_flt_cfg_t flt_decode(input logic [3:0] code);
        tccc_flt_cfg_t c;
        c.bypass = 1'b0;
        c.rate   = TCCC_SMP_KERNEL;
        c.count  = 4'h8;
        // R6 - kernel rate codes
        // R7 - dead-time pairs
        // R8 - slow dead-time codes
        case (code)
            4'h0:    c.bypass = 1'b1;
            4'h1:    c.count = 4'h2;
            4'h2:    c.count = 4'h4;
            4'h3:    c.count = 4'h8;
            4'h4:    begin c.rate = TCCC_SMP_DTS2;  c.count = 4'h6; end
            4'h5:    begin c.rate = TCCC_SMP_DTS2;  c.count = 4'h8; end
            4'h6:    begin c.rate = TCCC_SMP_DTS4;  c.count = 4'h6; end
            4'h7:    begin c.rate = TCCC_SMP_DTS4;  c.count = 4'h8; end
            4'h8:    begin c.rate = TCCC_SMP_DTS8;  c.count = 4'h6; end
            4'h9:    begin c.rate = TCCC_SMP_DTS8;  c.count = 4'h8; end
            4'hA:    begin c.rate = TCCC_SMP_DTS16; c.count = 4'h5; end
            4'hB:    begin c.rate = TCCC_SMP_DTS16; c.count = 4'h6; end
            4'hC:    begin c.rate = TCCC_SMP_DTS16; c.count = 4'h8; end
            4'hD:    begin c.rate = TCCC_SMP_DTS32; c.count = 4'h5; end
            4'hE:    begin c.rate = TCCC_SMP_DTS32; c.count = 4'h6; end
            default: begin c.rate = TCCC_SMP_DTS32; c.count = 4'h8; end
        endcase
        return c;
    endfunction

    // Sampling strobe for a given rate: every cycle at kernel rate, else from the dead-time divider edges
    function automatic logic smp_tick(input tccc_smp_t rate, input logic [4:0] rise,
                                      input logic dts);
        case (rate)
            TCCC_SMP_KERNEL: smp_tick = 1'b1;
            TCCC_SMP_DTS2:   smp_tick = rise[0];
            TCCC_SMP_DTS4:   smp_tick = rise[1];
            TCCC_SMP_DTS8:   smp_tick = rise[2];
            TCCC_SMP_DTS16:  smp_tick = rise[3];
            TCCC_SMP_DTS32:  smp_tick = rise[4];
            default:         smp_tick = dts;
        endcase
    endfunction

    // Pins pass two flops before any logic reads them
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_r   <= 2'h0;
            sync2_r   <= 2'h0;
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
        end else if (i_ce) begin
            sync1_r   <= i_ch_raw_input;
            sync2_r   <= sync1_r;
            trig_s1_r <= i_internal_trigger;
            trig_s2_r <= trig_s1_r;
        end
    end

    // Dead-time clock divider; a rising counter bit marks a divided tick
    always_comb begin
        dts_div_nxt = i_dts_tick ? dts_div_r + 5'h01 : dts_div_r;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dts_div_r  <= 5'h00;
            dts_prev_r <= 5'h00;
        end else if (i_ce) begin
            dts_div_r  <= dts_div_nxt;
            dts_prev_r <= dts_div_r;
        end
    end

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_flt
            tccc_flt_cfg_t cfg;
            // R14 - channel 0 fields
            // R15 - channel 1 fields
            assign cfg = flt_decode(mode_r[ch*CH_STRIDE+MC_FLT_LSB +: 4]);
            tccc_filter u_filter (
                .i_sys_clk  (i_sys_clk),
                .i_resetn   (i_resetn),
                .i_ce       (i_ce),
                .i_smp_tick (smp_tick(cfg.rate, dts_div_r & ~dts_prev_r, i_dts_tick)),
                .i_cfg      (cfg),
                .i_in       (sync2_r[ch]),
                .o_filt     (filt[ch])
            );
        end
    endgenerate

    // Register bus: one wait cycle, answer on the following edge
    assign wr_hit = i_avs_write && !ack_r;
    assign rd_hit = i_avs_read && !ack_r;

    always_comb begin
        logic [1:0] dir0;
        logic [1:0] dir1;
        dir0      = mode_r[MC_DIR_LSB +: 2];
        dir1      = mode_r[CH_STRIDE+MC_DIR_LSB +: 2];
        mode_nxt  = mode_r;
        ep_nxt    = ep_r;
        protection_level_nxt  = protection_level_r;
        ack_nxt   = (i_avs_read || i_avs_write) && !ack_r;
        wait_nxt  = !ack_nxt;
        rdata_nxt = 32'h0000_0000;
        if (wr_hit && i_avs_byteenable[1:0] == 2'h3) begin
            case (i_avs_address)
                MODE_CTRL_OFS: begin
                    mode_nxt = i_avs_writedata[15:0];
                    // R2 - direction locked while enabled
                    if (ep_r[EP_EN_BIT]) begin
                        mode_nxt[MC_DIR_LSB +: 2] = dir0;
                    end
                    if (ep_r[EP_STRIDE+EP_EN_BIT]) begin
                        mode_nxt[CH_STRIDE+MC_DIR_LSB +: 2] = dir1;
                    end
                end
                ENA_POL_OFS: begin
                    // R16 - defined bits only
                    ep_nxt = i_avs_writedata[15:0] & ENA_POL_MASK;
                    // R12 - lock complementary polarity
                    if (protection_level_r == PROTECTION_LEVEL_LOCK_A || protection_level_r == PROTECTION_LEVEL_LOCK_B) begin
                        ep_nxt[EP_NPOL_BIT] = ep_r[EP_NPOL_BIT];
                        ep_nxt[EP_STRIDE+EP_NPOL_BIT] = ep_r[EP_STRIDE+EP_NPOL_BIT];
                    end
                end
                PROTECT_OFS: protection_level_nxt = i_avs_writedata[1:0];
                default: ;
            endcase
        end
        if (rd_hit) begin
            case (i_avs_address)
                MODE_CTRL_OFS: rdata_nxt = {16'h0000, mode_r};
                ENA_POL_OFS:   rdata_nxt = {16'h0000, ep_r};
                PROTECT_OFS:   rdata_nxt = {30'h0, protection_level_r};
                STATUS_OFS:    rdata_nxt = {26'h0, out_r, sel_r, filt};
                default:       rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_r  <= MODE_CTRL_RST;
            ep_r    <= ENA_POL_RST;
            protection_level_r  <= PROTECT_RST;
            ack_r   <= 1'b0;
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else if (i_ce) begin
            mode_r  <= mode_nxt;
            ep_r    <= ep_nxt;
            protection_level_r  <= protection_level_nxt;
            ack_r   <= ack_nxt;
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_avs_waitrequest = wait_r;
    assign o_avs_readdata    = rdata_r;

    // Channel datapath
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            logic [1:0] dir;
            logic [1:0] div;
            logic [2:0] cmode;
            logic       en;
            logic       pol;
            logic       src;
            logic       hit;
            src   = 1'b0;
            hit   = 1'b0;
            dir   = mode_r[ch*CH_STRIDE+MC_DIR_LSB +: 2];
            div   = mode_r[ch*CH_STRIDE+MC_DIV_LSB +: 2];
            cmode = mode_r[ch*CH_STRIDE+MC_CMP_LSB +: 3];
            en    = ep_r[ch*EP_STRIDE+EP_EN_BIT];
            // R11 - polarity with complementary bit
            // R19 - falling edge inverts
            pol   = ep_r[ch*EP_STRIDE+EP_POL_BIT] & ~ep_r[ch*EP_STRIDE+EP_NPOL_BIT];
            // R3 - source selection
            case (dir)
                DIR_OWN_IN:   src = filt[ch];
                DIR_OTHER_IN: src = filt[1-ch];
                DIR_TRIG_IN:  src = trig_s2_r;
                default:      src = 1'b0;
            endcase
            pol_in[ch]   = src ^ pol;
            sel_nxt[ch]  = pol_in[ch];
            edge_now[ch] = pol_in[ch] & ~sel_r[ch] & (dir != DIR_OUTPUT);
            edge_cnt_nxt[ch] = edge_cnt_r[ch];
            cap_nxt[ch]  = 1'b0;
            sel_edge_nxt[ch] = edge_now[ch];
            // R10 - clear divider when disabled
            if (!en) begin
                edge_cnt_nxt[ch] = 3'h0;
            // R18 - capture only when enabled
            end else if (edge_now[ch]) begin
                // R9 - divide edges by 1/2/4/8
                hit = (edge_cnt_r[ch] & ((3'h1 << div) - 3'h1)) == ((3'h1 << div) - 3'h1);
                cap_nxt[ch] = hit;
                edge_cnt_nxt[ch] = hit ? 3'h0 : edge_cnt_r[ch] + 3'h1;
            end
            // R1 - fast compare on trigger edge
            fast_hold_nxt[ch] = mode_r[ch*CH_STRIDE+MC_FAST_BIT] && i_trig_edge &&
                                (cmode == PWM_FIRST_MODE || cmode == PWM_SECOND_MODE);
            // R13 - polarity 1 is active low
            out_nxt[ch] = (fast_hold_nxt[ch] ? (cmode == PWM_FIRST_MODE) : i_cmp_level[ch])
                          ^ ep_r[ch*EP_STRIDE+EP_POL_BIT];
            oen_nxt[ch] = en && dir == DIR_OUTPUT;
            if (!oen_nxt[ch]) begin
                out_nxt[ch] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_r         <= 2'h0;
            edge_cnt_r[0] <= 3'h0;
            edge_cnt_r[1] <= 3'h0;
            cap_r         <= 2'h0;
            sel_edge_r    <= 2'h0;
            out_r         <= 2'h0;
            oen_r         <= 2'h0;
        end else if (i_ce) begin
            sel_r         <= sel_nxt;
            edge_cnt_r[0] <= edge_cnt_nxt[0];
            edge_cnt_r[1] <= edge_cnt_nxt[1];
            cap_r         <= cap_nxt;
            sel_edge_r    <= sel_edge_nxt;
            out_r         <= out_nxt;
            oen_r         <= oen_nxt;
        end
    end

    assign o_ch_output     = out_r;
    assign o_ch_output_en  = oen_r;
    assign o_capture       = cap_r;
    assign o_selected_edge = sel_edge_r;
endmodule

/* sim/tccc_asserts.sv */
/*
 * Checker for tccc_top: register handshake, read data and output relations.
 * Assumes it is bound to tccc_top and sees only that module's ports.
 */
module tccc_asserts
    import tccc_pkg::*;
(
    input wire logic        i_sys_clk,          // Kernel clock
    input wire logic        i_resetn,           // Async reset, active low
    input wire logic [7:0]  i_avs_address,      // Byte address
    input wire logic        i_avs_read,         // Read request
    input wire logic        i_avs_write,        // Write request
    input wire logic [31:0] o_avs_readdata,     // Read data
    input wire logic        o_avs_waitrequest,  // Wait request
    input wire logic [1:0]  o_ch_output,        // Channel outputs
    input wire logic [1:0]  o_ch_output_en,     // Output enables
    input wire logic [1:0]  o_capture,          // Capture pulses
    input wire logic [1:0]  o_selected_edge     // Selected edge pulses
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    logic rd_ack;
    logic mapped;
    assign rd_ack = !o_avs_waitrequest && i_avs_read;
    assign mapped = i_avs_address inside {MODE_CTRL_OFS, ENA_POL_OFS, PROTECT_OFS, STATUS_OFS};

    a_ack_next:
        assert property ($rose(i_avs_read | i_avs_write) |=> !o_avs_waitrequest)
        else $error("waitrequest did not drop one cycle after a request");
    a_ack_single:
        assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest stayed low for more than one cycle");
    a_ack_has_req:
        assert property (!o_avs_waitrequest |-> $past(i_avs_read | i_avs_write))
        else $error("acknowledge without a request");
    a_read_upper_zero:
        assert property (rd_ack |-> o_avs_readdata[31:16] == 16'h0000)
        else $error("upper half of read data not zero");
    a_unmapped_zero:
        assert property (rd_ack && !mapped |-> o_avs_readdata == 32'h0000_0000)
        else $error("unmapped address returned data");
    a_reserved_zero:
        assert property (rd_ack && i_avs_address == ENA_POL_OFS
                         |-> (o_avs_readdata[15:0] & ~ENA_POL_MASK) == 16'h0000)
        else $error("reserved enable bits read nonzero");
    a_idle_out_low:
        assert property ((o_ch_output & ~o_ch_output_en) == 2'b00)
        else $error("output high while not driven");
    a_capture_pulse:
        assert property (o_capture != 2'b00 |=> (o_capture & $past(o_capture)) == 2'b00)
        else $error("capture pulse longer than one cycle");
    a_edge_pulse:
        assert property (o_selected_edge != 2'b00
                         |=> (o_selected_edge & $past(o_selected_edge)) == 2'b00)
        else $error("edge pulse longer than one cycle");
endmodule

/* sim/tccc_top_tb.sv */
/*
 * Self-checking bench for tccc_top with a register model kept in integers.
 * Assumes the checker module tccc_asserts is compiled before this file.
 */
module tccc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tccc_pkg::*;

    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        trig = 1'b0;
    logic        itrig = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [1:0]  pin = 2'b00;
    logic [1:0]  cmp = 2'b00;
    logic [31:0] rdata;
    logic [31:0] q;
    logic        wreq;
    logic [1:0]  och, oen, cap, sel;
    int          error_cnt = 0, cmp_count = 0, seed = 837;
    int          ep_m = 0, mc_m = 0, protection_level_m = 0, cap_n = 0, sel_n = 0, b1, b2, hit;
    int          fc[6] = '{1, 3, 4, 9, 10, 15};
    int          fn[6] = '{2, 8, 6, 8, 5, 8};
    int          fd[6] = '{1, 1, 2, 8, 16, 32};

    tccc_top tccc_top_inst (
        .i_sys_clk(clk), .i_resetn(resetn), .i_ce(1'b1), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_dts_tick(1'b1), .i_ch_raw_input(pin), .i_internal_trigger(itrig),
        .i_trig_edge(trig), .i_cmp_level(cmp), .o_ch_output(och),
        .o_ch_output_en(oen), .o_capture(cap), .o_selected_edge(sel)
    );

    always #50 clk = ~clk;
    always @(posedge clk) begin
        cap_n += int'(cap[0]);
        sel_n += int'(sel[0]);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= {16'h0000, d};
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 64);
        if (n >= 64) error_cnt++;
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        int lk;
        bus(1'b1, a, d);
        lk = (protection_level_m >= 2) ? 'h88 : 0;
        if (a == ENA_POL_OFS) ep_m = int'(d & ENA_POL_MASK) & ~lk | ep_m & lk;
        lk = (ep_m & 1 ? 3 : 0) | (ep_m & 'h10 ? 'h300 : 0);
        if (a == MODE_CTRL_OFS) mc_m = int'(d) & ~lk | mc_m & lk;
        if (a == PROTECT_OFS) protection_level_m = int'(d) & 3;
    endtask

    task automatic rreg(input logic [7:0] a, input int exp);
        bus(1'b0, a, 16'h0000);
        chk(q, 32'(exp));
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic drive(input int s, input logic v, input int n);
        @(posedge clk);
        if (s == 2) itrig <= v;
        else pin[s] <= v;
        repeat (n - 1) @(posedge clk);
    endtask

    task automatic pulse(input int s, input int hi, input int lo);
        drive(s, 1'b1, hi);
        drive(s, 1'b0, lo);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Generous: the longest filter runs take a few hundred cycles each
    initial begin
        #5_000_000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rreg(MODE_CTRL_OFS, int'(MODE_CTRL_RST));
        rreg(ENA_POL_OFS, int'(ENA_POL_RST));
        rreg(8'h30, 0);
        repeat (6) begin
            wreg(ENA_POL_OFS, 16'($random(seed)) & 16'hFF77);
            rreg(ENA_POL_OFS, ep_m);
        end
        wreg(ENA_POL_OFS, 16'h0000);
        wreg(MODE_CTRL_OFS, 16'h0101);
        wreg(ENA_POL_OFS, 16'h0011);
        wreg(MODE_CTRL_OFS, 16'h0202);
        rreg(MODE_CTRL_OFS, mc_m);
        wreg(ENA_POL_OFS, 16'h0000);
        wreg(MODE_CTRL_OFS, 16'h0202);
        rreg(MODE_CTRL_OFS, mc_m);
        for (int p = 0; p < 4; p++) begin
            wreg(PROTECT_OFS, 16'(p));
            wreg(ENA_POL_OFS, 16'h0088);
            rreg(ENA_POL_OFS, ep_m);
            wreg(ENA_POL_OFS, 16'h0000);
        end
        wreg(PROTECT_OFS, 16'h0000);
        wreg(ENA_POL_OFS, 16'h0000);
        $display("test registers done");
        wreg(MODE_CTRL_OFS, 16'h0000);
        for (int k = 0; k < 16; k++) begin
            wreg(ENA_POL_OFS, 16'h0011 | 16'(k >> 2 & 1) << 1 | 16'(k >> 3) << 5);
            cmp <= 2'(k);
            settle(4);
            chk({30'h0, oen}, 32'h3);
            chk({30'h0, och}, 32'((k ^ k >> 2) & 3));
        end
        for (int k = 0; k < 4; k++) begin
            wreg(ENA_POL_OFS, 16'h0000);
            wreg(MODE_CTRL_OFS, 16'((6 + (k & 1)) << 4 | (k >> 1) << 2));
            cmp <= 2'(k & 1);
            wreg(ENA_POL_OFS, 16'h0001);
            settle(4);
            hit = 0;
            @(posedge clk);
            trig <= 1'b1;
            @(posedge clk);
            trig <= 1'b0;
            repeat (3) begin
                @(negedge clk);
                if (och[0] !== 1'(k & 1)) hit = 1;
            end
            chk(32'(hit), 32'(k >> 1));
        end
        wreg(ENA_POL_OFS, 16'h0000);
        $display("test outputs done");
        for (int k = 0; k < 4; k++) begin
            wreg(MODE_CTRL_OFS, 16'(k << 2 | 1));
            wreg(ENA_POL_OFS, 16'h0001);
            b1 = cap_n;
            b2 = sel_n;
            repeat (15) pulse(0, 3, 3);
            settle(8);
            chk(32'(cap_n - b1), 32'(15 >> k));
            chk(32'(sel_n - b2), 32'd15);
            wreg(ENA_POL_OFS, 16'h0000);
        end
        for (int p = 0; p < 2; p++) begin
            wreg(ENA_POL_OFS, 16'(1 | p << 1));
            // A polarity switch itself can show as one edge
            settle(4);
            b2 = sel_n;
            drive(0, 1'b1, 1);
            settle(8);
            chk(32'(sel_n - b2), 32'(1 - p));
            drive(0, 1'b0, 1);
            settle(8);
            chk(32'(sel_n - b2), 32'd1);
        end
        for (int k = 1; k < 4; k++) begin
            wreg(ENA_POL_OFS, 16'h0000);
            wreg(MODE_CTRL_OFS, 16'(k));
            wreg(ENA_POL_OFS, 16'h0001);
            b2 = sel_n;
            for (int s = 0; s < 3; s++) begin
                pulse(s, 3, 3);
                settle(6);
            end
            chk(32'(sel_n - b2), 32'd1);
        end
        $display("test capture done");
        // Two short runs split by one low sample must not add up to a pass
        for (int k = 0; k < 6; k++) begin
            wreg(ENA_POL_OFS, 16'h0000);
            wreg(MODE_CTRL_OFS, 16'(fc[k] << 4 | 1));
            wreg(ENA_POL_OFS, 16'h0001);
            b2 = sel_n;
            pulse(0, fn[k] * fd[k] * 3 / 4, fd[k]);
            pulse(0, fn[k] * fd[k] * 3 / 4, fn[k] * fd[k] * 2 + 6);
            chk(32'(sel_n - b2), 32'd0);
            pulse(0, fn[k] * fd[k] * 2 + 6, fn[k] * fd[k] * 2 + 6);
            chk(32'(sel_n - b2), 32'd1);
        end
        $display("test filter done");
        tally_and_finish();
    end
endmodule

bind tccc_top tccc_asserts tccc_asserts_inst (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_ch_output(o_ch_output),
    .o_ch_output_en(o_ch_output_en), .o_capture(o_capture),
    .o_selected_edge(o_selected_edge)
);
